//--- pkg/nsov_pkg.sv
// Purpose: shared constants and types for the negative-sequence overvoltage block
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   magnitude is given in percent of rated voltage, 8.8 fixed point
package nsov_pkg;
    // register byte offsets
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_LEVEL     = 8'h04;
    localparam logic [7:0]  ADDR_DELAY     = 8'h08;
    localparam logic [7:0]  ADDR_STATUS    = 8'h0c;
    localparam logic [7:0]  ADDR_MAG       = 8'h10;
    // control field positions
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_SONLY_BIT = 1;
    // reset values and ranges
    localparam logic [1:0]  CTRL_RST       = 2'h1;
    localparam logic [7:0]  LEVEL_RST      = 8'h1e;
    localparam logic [7:0]  LEVEL_MIN      = 8'h02;
    localparam logic [7:0]  LEVEL_MAX      = 8'h28;
    localparam logic [15:0] DELAY_RST      = 16'h0064;
    localparam logic [15:0] DELAY_MIN      = 16'h0032;
    localparam logic [15:0] DELAY_MAX      = 16'hea60;
    // timing: one millisecond tick
    localparam int          CLK_HZ         = 125000000;
    localparam int          TICK_MS        = 1;
    localparam int          TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;

    // measured magnitude word from the upstream stage
    typedef struct packed {
        logic        valid;
        logic [15:0] pct_q8;
    } nsov_mag_s;

    // timing states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_TIME  = 2'b01,
        ST_TRIP  = 2'b10
    } nsov_state_e;
endpackage : nsov_pkg

//--- core/nsov_top.sv
// Purpose: definite-time negative-sequence overvoltage start and trip
// Assumes: magnitude input is synchronous to clk; block input is a pin
// Notes:   settings over apb; out-of-range settings are clamped on write
//          apb answers without wait states; pslverr marks an unmapped word
//          status and magnitude words are read-only, writes to them do nothing
//          the millisecond tick restarts at each start, so a trip lands exactly
//          delay times tick cycles after start; no hysteresis on the level
//          block input is asynchronous and costs two cycles of synchronisation
//
// Functional notes
// - start and general start when above level
// - trip only after delay, not start-only
// - enable bit or block input suppresses all
// - start level percent 2..40, default 30
// - delay ms 50..60000, default 100
// - start-only flag prevents any trip
// - count delay only while above threshold
// - operate time fixed, independent of excess
// - trip combines start, trip, flag, block
`timescale 1ns/1ns
module nsov_top #(
    parameter int TICK_CYC = nsov_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // measurement and user logic
    input  wire nsov_pkg::nsov_mag_s mag,
    input  wire logic              block_input,
    // protection outputs
    output logic                   general_start_out,
    output logic                   general_trip_out
);
    // register state
    logic [1:0]  ctrl_r, ctrl_nxt;
    logic [7:0]  level_r, level_nxt;
    logic [15:0] delay_r, delay_nxt;
    logic [15:0] mag_r, mag_nxt;
    logic [31:0] prdata_nxt;
    logic        pslverr_nxt;
    logic        pready_nxt;
    // block input synchroniser
    logic        blk_s1_r, blk_s2_r;
    // timing state
    nsov_pkg::nsov_state_e state_r, state_nxt;
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic [15:0] ms_cnt_r, ms_cnt_nxt;
    logic        gst_nxt, gtr_nxt;
    logic        above, enabled, access, tick;
    // apb phase decode shared by the read mux and the write strobe
    logic        setup, wr_en;

    // clamp a value into its settable range
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp16

    assign access  = psel & penable;
    assign setup   = psel & ~penable;
    // a write lands only at the edge that also sees pready
    assign wr_en   = access & pready & pwrite;
    // strict greater-than: sitting exactly on the level is not a start
    assign above   = mag_r > {level_r, 8'h00};
    assign enabled = ctrl_r[nsov_pkg::CTRL_EN_BIT] & ~blk_s2_r;
    // divider enable: one pulse per millisecond of trip delay
    assign tick    = tick_cnt_r == 32'(TICK_CYC - 1);

    // register file next values and apb answer, zero wait states
    always_comb begin
        ctrl_nxt    = ctrl_r;
        level_nxt   = level_r;
        delay_nxt   = delay_r;
        prdata_nxt  = prdata;
        pslverr_nxt = 1'b0;
        pready_nxt  = setup;
        // read word chosen in setup, so it stands registered beside pready
        if (setup) begin
            prdata_nxt = 32'h0000_0000;
            case (paddr)
                nsov_pkg::ADDR_CTRL:   prdata_nxt = {30'h0, ctrl_r};
                nsov_pkg::ADDR_LEVEL:  prdata_nxt = {24'h0, level_r};
                nsov_pkg::ADDR_DELAY:  prdata_nxt = {16'h0, delay_r};
                nsov_pkg::ADDR_STATUS: prdata_nxt = {30'h0, general_trip_out,
                                                     general_start_out};
                nsov_pkg::ADDR_MAG:    prdata_nxt = {16'h0, mag_r};
                default:               pslverr_nxt = 1'b1;
            endcase
        end
        // clamping on write keeps the timer and comparator in range
        if (wr_en) begin
            case (paddr)
                nsov_pkg::ADDR_CTRL:  ctrl_nxt = pwdata[1:0];
                nsov_pkg::ADDR_LEVEL: level_nxt = 8'(clamp16({8'h0, pwdata[7:0]},
                                          {8'h0, nsov_pkg::LEVEL_MIN},
                                          {8'h0, nsov_pkg::LEVEL_MAX}));
                nsov_pkg::ADDR_DELAY: delay_nxt = clamp16(pwdata[15:0],
                                          nsov_pkg::DELAY_MIN,
                                          nsov_pkg::DELAY_MAX);
                default: ;
            endcase
        end
    end

    // magnitude latch; a cycle with no fresh word keeps the last one
    always_comb begin
        mag_nxt = mag.valid ? mag.pct_q8 : mag_r;
    end

    // settings flops; the defaults return on every reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r  <= nsov_pkg::CTRL_RST;
            level_r <= nsov_pkg::LEVEL_RST;
            delay_r <= nsov_pkg::DELAY_RST;
        end else begin
            ctrl_r  <= ctrl_nxt;
            level_r <= level_nxt;
            delay_r <= delay_nxt;
        end
    end

    // magnitude flop; zero after reset so nothing starts before a first word
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mag_r <= 16'h0000;
        end else begin
            mag_r <= mag_nxt;
        end
    end

    // apb answer flops; pslverr stands only beside pready, never after it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // block input is asynchronous user logic, two flops before use
    // only the second flop feeds logic; the first may settle late
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blk_s1_r <= 1'b0;
            blk_s2_r <= 1'b0;
        end else begin
            blk_s1_r <= block_input;
            blk_s2_r <= blk_s1_r;
        end
    end

    // definite-time characteristic and decision logic
    always_comb begin
        state_nxt    = state_r;
        ms_cnt_nxt   = ms_cnt_r;
        tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
        case (state_r)
            nsov_pkg::ST_IDLE: begin
                ms_cnt_nxt   = 16'h0000;
                tick_cnt_nxt = 32'h0;   // timing starts aligned to the start edge
                if (enabled & above)
                    state_nxt = nsov_pkg::ST_TIME;
            end
            // elapsed ticks alone decide; the size of the excess plays no part
            nsov_pkg::ST_TIME: begin
                if (tick)
                    ms_cnt_nxt = ms_cnt_r + 16'h1;
                if (tick & (ms_cnt_r + 16'h1 >= delay_r))
                    state_nxt = nsov_pkg::ST_TRIP;
            end
            // trip stands until the start condition goes away
            nsov_pkg::ST_TRIP: ;
            default: state_nxt = nsov_pkg::ST_IDLE;
        endcase
        // any drop, block or disable restarts timing from zero
        if (!(enabled & above)) begin
            state_nxt  = nsov_pkg::ST_IDLE;
            ms_cnt_nxt = 16'h0000;
        end
        // trip needs start still present; start-only masks it here
        gst_nxt = enabled & above;
        gtr_nxt = (state_nxt == nsov_pkg::ST_TRIP) & gst_nxt &
                  ~ctrl_r[nsov_pkg::CTRL_SONLY_BIT];
    end

    // timing flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r           <= nsov_pkg::ST_IDLE;
            tick_cnt_r        <= 32'h0;
            ms_cnt_r          <= 16'h0000;
        end else begin
            state_r           <= state_nxt;
            tick_cnt_r        <= tick_cnt_nxt;
            ms_cnt_r          <= ms_cnt_nxt;
        end
    end

    // protection outputs straight from flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            general_start_out <= 1'b0;
            general_trip_out  <= 1'b0;
        end else begin
            general_start_out <= gst_nxt;
            general_trip_out  <= gtr_nxt;
        end
    end
endmodule : nsov_top

//--- tb/nsov_checker.sv
// Purpose: port assertions for the overvoltage block
// Assumes: level setting never above 40 percent
// Notes:   trip time counted in started cycles
`timescale 1ns/1ns
module nsov_checker #(
    parameter int TICK_CYC = 4
) (
    // clock, reset, apb
    input wire logic                clk,
    input wire logic                rstn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic                pready,
    input wire logic                pslverr,
    // protection
    input wire nsov_pkg::nsov_mag_s mag,
    input wire logic                block_input,
    input wire logic                general_start_out,
    input wire logic                general_trip_out
);
    int         run_r;
    int         run_nxt;
    logic [1:0] ctrl_r;
    logic [1:0] ctrl_nxt;
    // started cycles; a trip before the minimum delay is early
    always_comb run_nxt = general_start_out ? run_r + 1 : 0;
    // control word as last written over apb, so disable and start-only are known here
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (psel && penable && pready && pwrite && paddr == nsov_pkg::ADDR_CTRL) begin
            ctrl_nxt = pwdata[1:0];
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_r  <= 0;
            ctrl_r <= nsov_pkg::CTRL_RST;
        end else begin
            run_r  <= run_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // above the highest settable level while enabled and not blocked
    sequence s_over;
        mag.valid && mag.pct_q8 > 16'h2800 && !block_input && ctrl_r[nsov_pkg::CTRL_EN_BIT];
    endsequence
    sequence s_low; mag.valid && mag.pct_q8 < 16'h0200; endsequence
    sequence s_trip_armed; general_trip_out && !ctrl_r[nsov_pkg::CTRL_SONLY_BIT]; endsequence
    AST_OVER_STARTS: assert property (s_over [*5] |-> general_start_out)
        else $error("no start above level");
    AST_LOW_DROPS: assert property (s_low |-> ##2 !general_start_out)
        else $error("start kept below level");
    AST_BLOCK_QUIET: assert property (block_input [*4] |->
        !general_start_out && !general_trip_out)
        else $error("output while blocked");
    AST_SONLY_NO_TRIP: assert property (ctrl_r[nsov_pkg::CTRL_SONLY_BIT] |=>
        !general_trip_out)
        else $error("trip while start-only");
    AST_TRIP_NEEDS_START: assert property (general_trip_out |-> general_start_out)
        else $error("trip without start");
    AST_TRIP_LATE: assert property ($rose(general_trip_out) |-> run_r >= 50 * TICK_CYC)
        else $error("trip too early");
    AST_TRIP_HOLDS: assert property ((s_trip_armed and s_over) |=> general_trip_out)
        else $error("trip lost while above");
    AST_APB_NO_WAIT: assert property (psel && !penable |=> pready)
        else $error("apb wait state");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : nsov_checker

//--- tb/nsov_mag_src.sv
// Purpose: upstream magnitude stage model
// Assumes: one fresh word every clock after reset
// Notes:   one register of latency, like a real stage
`timescale 1ns/1ns
module nsov_mag_src (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rstn,
    // request and word to the block
    input  wire logic [15:0]   pct_req,
    output nsov_pkg::nsov_mag_s mag
);
    nsov_pkg::nsov_mag_s mag_r;
    nsov_pkg::nsov_mag_s mag_nxt;
    // rms magnitude word; invalid during reset so nothing stale is taken
    always_comb mag_nxt = {1'b1, pct_req};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) mag_r <= {1'b0, 16'hffff};
        else mag_r <= mag_nxt;
    end
    assign mag = mag_r;
endmodule : nsov_mag_src

//--- tb/nsov_top_tb.sv
// Purpose: self-checking bench for the overvoltage block
// Assumes: four clocks per millisecond tick
// Notes:   settings table first, then timing cases
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
    mismatches++; $display("BAD %0t mismatch", $time); end end
module nsov_top_tb;
    typedef struct { logic w; logic [7:0] a; logic [31:0] d, x; logic e; } nsov_row_s;
    logic                clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic                block_input = 0, pready, pslverr, er, st, tr;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0, prdata, rd;
    logic [15:0]         pct = 16'h0000;
    nsov_pkg::nsov_mag_s mag;
    int                  mismatches = 0, comparisons = 0, cyc = 0, n;
    nsov_row_s           rows [9] = '{'{0, 8'h00, 0, 32'h1, 0}, '{0, 8'h04, 0, 32'h1e, 0},
        '{0, 8'h08, 0, 32'h64, 0}, '{0, 8'h0c, 0, 32'h0, 0}, '{1, 8'h04, 32'h29, 32'h28, 0},
        '{1, 8'h04, 32'h1, 32'h2, 0}, '{1, 8'h08, 32'h31, 32'h32, 0},
        '{1, 8'h08, 32'hea61, 32'hea60, 0}, '{1, 8'h14, 32'h5, 32'h0, 1}};
    nsov_top #(.TICK_CYC(4)) dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mag(mag), .block_input(block_input),
        .general_start_out(st), .general_trip_out(tr));
    nsov_mag_src u_src (.clk(clk), .rstn(rstn), .pct_req(pct), .mag(mag));
    always #4 clk = ~clk;
    // hang guard, far above the longest case
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            close_out;
        end
    end
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no wait count assumed; only the hang guard ends a lost answer
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task settle(input logic [15:0] p, input int c);
        pct <= p;
        repeat (c) @(posedge clk);
    endtask : settle
    // cycles from start to trip, 300 meaning none
    task run(input logic [15:0] p, output int k);
        pct <= p;
        k = 0;
        while (st !== 1'b1 && k < 8) begin @(posedge clk); k++; end
        k = 0;
        while (tr !== 1'b1 && k < 300) begin @(posedge clk); k++; end
    endtask : run
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            `CHK({er, rd}, {rows[i].e, rows[i].x});
        end
        apb(1'b1, nsov_pkg::ADDR_LEVEL, 32'ha);
        apb(1'b1, nsov_pkg::ADDR_DELAY, 32'h32);
        run(16'h0b00, n);
        `CHK(n >= 199 && n <= 203, 1'b1);
        apb(1'b0, nsov_pkg::ADDR_STATUS, 32'h0);
        `CHK(rd[1:0], 2'h3);
        apb(1'b0, nsov_pkg::ADDR_MAG, 32'h0);
        `CHK(rd, 32'h0000_0b00);
        settle(16'h0a00, 6);
        `CHK({st, tr}, 2'b00);
        // partial event, drop, then a large excess must time from zero
        settle(16'h0b00, 100);
        settle(16'h0000, 4);
        run(16'h2900, n);
        `CHK(n >= 199 && n <= 203, 1'b1);
        settle(16'h0000, 4);
        apb(1'b1, nsov_pkg::ADDR_CTRL, 32'h3);
        run(16'h2900, n);
        `CHK({st, tr, n == 300}, 3'b101);
        apb(1'b1, nsov_pkg::ADDR_CTRL, 32'h1);
        block_input <= 1'b1;
        settle(16'h2900, 8);
        `CHK({st, tr}, 2'b00);
        block_input <= 1'b0;
        apb(1'b1, nsov_pkg::ADDR_CTRL, 32'h0);
        settle(16'h2900, 8);
        `CHK(st, 1'b0);
        apb(1'b1, nsov_pkg::ADDR_CTRL, 32'h1);
        settle(16'h2900, 8);
        `CHK(st, 1'b1);
        // reset in mid-run: outputs clear at once, settings return to defaults
        rstn <= 1'b0;
        @(posedge clk);
        `CHK({st, tr}, 2'b00);
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(1'b0, nsov_pkg::ADDR_LEVEL, 32'h0);
        `CHK(rd, 32'h0000_001e);
        apb(1'b0, nsov_pkg::ADDR_DELAY, 32'h0);
        `CHK(rd, 32'h0000_0064);
        close_out;
    end
endmodule : nsov_top_tb
bind nsov_top nsov_checker #(.TICK_CYC(TICK_CYC)) u_chk (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .mag(mag),
    .block_input(block_input), .general_start_out(general_start_out),
    .general_trip_out(general_trip_out));
